/* File: sac_core_model.sv */
`timescale 1ns/1ps
module sac_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Requests
    input wire logic anaStart,
    input wire logic anaCalibrate,
    input wire logic dmaReq,
    // Settings
    input wire logic [15:0] rawIn,
    input wire logic [3:0] dly,
    // Answers
    output logic anaDone,
    output logic [15:0] anaData,
    output logic anaCalDone,
    output logic dmaAck
);
    logic [4:0] convCnt;
    logic [3:0] calCnt, ackCnt;
    always @(posedge mclk) begin
        anaDone <= 1'b0;
        anaData <= ~anaData; // Never stale outside done
        anaCalDone <= (calCnt == 4'h9);
        calCnt <= (anaCalibrate && !anaCalDone) ? calCnt + 4'h1 : 4'h0;
        ackCnt <= (dmaReq && !dmaAck) ? ackCnt + 4'h1 : 4'h0;
        dmaAck <= dmaReq && !dmaAck && ackCnt == dly;
        convCnt <= anaStart ? 5'h14 : convCnt - 5'(convCnt != 5'h0);
        if (convCnt == 5'h1) begin
            anaDone <= 1'b1;
            anaData <= rawIn;
        end
        if (!rst_n) begin
            {anaDone, anaCalDone, dmaAck, calCnt, ackCnt, convCnt} <= '0;
            anaData <= 16'h5a5a;
        end
    end
endmodule : sac_core_model

/* File: sac_pkg.sv */
package sac_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int RAW_BITS = 14;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_TASK_START = 12'h000;
    localparam logic [11:0] OFS_TASK_SAMPLE = 12'h004;
    localparam logic [11:0] OFS_TASK_STOP = 12'h008;
    localparam logic [11:0] OFS_TASK_CAL = 12'h00c;
    localparam logic [11:0] OFS_EVENTS = 12'h100;
    localparam logic [11:0] OFS_STATUS = 12'h200;
    localparam logic [11:0] OFS_RESOLUTION = 12'h204;
    localparam logic [11:0] OFS_OVERSAMPLE = 12'h208;
    localparam logic [11:0] OFS_SAMPLERATE = 12'h20c;
    localparam logic [11:0] OFS_RESULT_BUFFER_POINTER = 12'h210;
    localparam logic [11:0] OFS_RESULT_BUFFER_MAX_COUNT = 12'h214;
    localparam logic [11:0] OFS_RESULT_AMOUNT = 12'h218;
    localparam logic [3:0] OFS_CH_REGION = 4'h3;
    localparam logic [1:0] CH_POS_SEL = 2'h0;
    localparam logic [1:0] CH_NEG_SEL = 2'h1;
    localparam logic [1:0] CH_CONFIG = 2'h2;
    localparam logic [1:0] CH_LIMIT = 2'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_GAIN_LSB = 8;
    localparam int CFG_REFERENCE_SELECT_BIT = 12;
    localparam int CFG_TACQ_LSB = 16;
    localparam int CFG_MODE_BIT = 20;
    localparam int CFG_BURST_BIT = 24;
    localparam int SR_MODE_BIT = 12;
    localparam int LIM_HIGH_LSB = 16;

    localparam int EV_STARTED = 0;
    localparam int EV_END = 1;
    localparam int EV_DONE = 2;
    localparam int EV_RESULTDONE = 3;
    localparam int EV_CALDONE = 4;
    localparam int EV_STOPPED = 5;
    localparam int EV_LIMIT_HIGH = 6;
    localparam int EV_LIMIT_LOW = 7;

    // ------------------------------------------------------------
    // Pin codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] PIN_NC = 4'h0;
    localparam logic [3:0] PIN_VDD = 4'h9;
    localparam logic [1:0] RESOLUTION_RST = 2'h1;
    localparam logic [31:0] LIMIT_RST = 32'h7fff8000;
    localparam logic [10:0] SAMCC_RST = 11'h7ff;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ACQ, PH_CONV, PH_DMA, PH_CAL
    } sac_phase_type;

    // Acquisition time code to cycles: 3, 5, 10, 15, 20, 40 us
    function automatic logic [15:0] sac_tacq_cycles(input logic [2:0] code);
        int us;
        unique case (code)
            3'h0: us = 3;
            3'h1: us = 5;
            3'h2: us = 10;
            3'h3: us = 15;
            3'h4: us = 20;
            default: us = 40;
        endcase
        return 16'(us * (CLK_HZ / 1_000_000));
    endfunction : sac_tacq_cycles

    // 14-bit only counts while oversampling
    function automatic logic [3:0] sac_res_bits(input logic [1:0] code, input logic ovs);
        if (code == 2'h3 && !ovs) begin
            return 4'hc;
        end
        return 4'(8 + 2 * code);
    endfunction : sac_res_bits

    // Lowest enabled channel at or above start; bit 3 set means none
    function automatic logic [3:0] sac_next_chan(input logic [7:0] en, input logic [3:0] start);
        for (int i = 0; i < 8; i++) begin
            if (en[i] && 4'(i) >= start) begin
                return 4'(i);
            end
        end
        return 4'h8;
    endfunction : sac_next_chan

endpackage : sac_pkg

/* File: sac_rate_timer.sv */
`timescale 1ns/1ps

module sac_rate_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [10:0] period,
    // Sample tick
    output logic tick
);
    import sac_pkg::*;

    typedef struct packed {
        logic [10:0] cnt;
        logic tick;
    } sac_timer_type;

    sac_timer_type s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!enable) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= period) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 11'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule : sac_rate_timer

/* File: sac_result_shape.sv */
`timescale 1ns/1ps

module sac_result_shape (
    // Raw core code, full scale at RAW_BITS
    input wire logic [15:0] rawCode,
    // Coding
    input wire logic [3:0] resBits,
    input wire logic diffMode,
    // Two's complement result
    output logic [15:0] shaped
);
    import sac_pkg::*;

    logic [4:0] shift;

    always_comb begin
        shift = 5'(RAW_BITS) - {1'b0, resBits} + {4'h0, diffMode};
        shaped = 16'($signed(rawCode) >>> shift);
    end

endmodule : sac_result_shape

/* File: sac_sar_converter.sv */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - Resolution 8/10/12, 14 only when oversampling
// - Eight channels, single-ended or differential mix
// - Scan mixes single-ended and differential channels
// - Sample task from software or interconnect
// - One-shot: one channel per trigger
// - Scan gap is acquisition, conversion and the DMA write
// - Results written to RAM by DMA
// - Events on sample done and buffer full
// - Results are 16-bit two's complement
// - Internal timer samples continuously, except in scan mode
// - Each result checked against limits
// - Input select: eight pins or supply
// - Channel mode resets to single-ended
// - Single-ended grounds the negative input
// - Result scaled by two to resolution minus m
// - Per-channel gain selection field
// - Calibrate task then calibration done event
// - Positive select enables; several mean scan
// - Scan: one sample converts every enabled channel
// - Done raised per sample, before RAM
module sac_sar_converter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Tasks from event interconnect
    input wire logic taskStartIn,
    input wire logic taskSampleIn,
    input wire logic taskStopIn,
    input wire logic taskCalIn,
    // Event pulses to event interconnect
    output logic [7:0] evtPulse,
    // Analog core and input multiplexers
    output logic [3:0] anaPosSel,
    output logic [3:0] anaNegSel,
    output logic anaNegGround,
    output logic [2:0] anaGain,
    output logic anaRefSel,
    output logic anaStart,
    output logic anaCalibrate,
    input wire logic anaDone,
    input wire logic [15:0] anaData,
    input wire logic anaCalDone,
    // DMA write master
    output logic dmaReq,
    output logic [31:0] dmaAddr,
    output logic [31:0] dmaData,
    output logic [3:0] dmaStrb,
    input wire logic dmaAck
);
    import sac_pkg::*;

    typedef struct packed {
        sac_phase_type ph;
        logic [7:0][3:0] posSel;
        logic [7:0][3:0] negSel;
        logic [7:0][2:0] gain;
        logic [7:0][2:0] tacq;
        logic [7:0] reference_select;
        logic [7:0] diffMode;
        logic [7:0] burst;
        logic [7:0][31:0] limit;
        logic [1:0] resolution;
        logic [3:0] overs;
        logic samMode;
        logic [10:0] samCc;
        logic [31:0] ptr;
        logic [14:0] maxCnt;
        logic [31:0] ptrL;
        logic [14:0] maxL;
        logic [14:0] amount;
        logic running;
        logic armed;
        logic stopPend;
        logic calPend;
        logic [2:0] chan;
        logic [15:0] tmr;
        logic [23:0] acc;
        logic [8:0] ovCnt;
        logic [7:0] evt;
        logic [7:0] evtPulse;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] anaPosSel;
        logic [3:0] anaNegSel;
        logic anaNegGround;
        logic [2:0] anaGain;
        logic anaRefSel;
        logic anaStart;
        logic anaCalibrate;
        logic dmaReq;
        logic [31:0] dmaAddr;
        logic [31:0] dmaData;
        logic [3:0] dmaStrb;
    } sac_state_type;

    sac_state_type s_r, s_nxt;

    logic tick;
    logic [15:0] shaped;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cfg_word(input sac_state_type s, input logic [2:0] c);
        logic [31:0] w;
        w = '0;
        w[CFG_GAIN_LSB +: 3] = s.gain[c];
        w[CFG_REFERENCE_SELECT_BIT] = s.reference_select[c];
        w[CFG_TACQ_LSB +: 3] = s.tacq[c];
        w[CFG_MODE_BIT] = s.diffMode[c];
        w[CFG_BURST_BIT] = s.burst[c];
        return w;
    endfunction : cfg_word

    // Point the multiplexers at channel c and start acquisition
    function automatic sac_state_type enter_acq(input sac_state_type s, input logic [2:0] c);
        sac_state_type t;
        t = s;
        t.ph = PH_ACQ;
        t.chan = c;
        t.tmr = sac_tacq_cycles(s.tacq[c]);
        t.anaPosSel = s.posSel[c];
        t.anaNegSel = s.diffMode[c] ? s.negSel[c] : PIN_NC;
        t.anaNegGround = !s.diffMode[c];
        t.anaGain = s.gain[c];
        t.anaRefSel = s.reference_select[c];
        return t;
    endfunction : enter_acq

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    logic [7:0] chEn;
    logic scanMode;
    logic ovsOn;

    assign chEn = {s_r.posSel[7] != PIN_NC, s_r.posSel[6] != PIN_NC,
                   s_r.posSel[5] != PIN_NC, s_r.posSel[4] != PIN_NC,
                   s_r.posSel[3] != PIN_NC, s_r.posSel[2] != PIN_NC,
                   s_r.posSel[1] != PIN_NC, s_r.posSel[0] != PIN_NC};
    assign scanMode = (chEn & (chEn - 8'h1)) != 8'h0;
    // Oversampling would average across channels, so scan turns it off
    assign ovsOn = (s_r.overs != 4'h0) && !scanMode;

    sac_rate_timer u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(s_r.running && s_r.armed && s_r.samMode && !scanMode),
        .period(s_r.samCc),
        .tick(tick)
    );

    sac_result_shape u_shape (
        .rawCode(anaData),
        .resBits(sac_res_bits(s_r.resolution, ovsOn)),
        .diffMode(s_r.diffMode[s_r.chan]),
        .shaped(shaped)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr;
        logic tStart;
        logic tSample;
        logic tStop;
        logic tCal;
        logic trig;
        logic goNext;
        logic hit;
        logic [2:0] c;
        logic [3:0] nc;
        logic [7:0] set;
        logic [7:0] clr;
        logic [23:0] sum;
        logic [15:0] res;
        logic [31:0] rd;
        logic [31:0] byteAddr;
        wr = psel && penable && s_r.pready && pwrite;
        tStart = taskStartIn || (wr && paddr == OFS_TASK_START && pwdata[0]);
        tSample = taskSampleIn || (wr && paddr == OFS_TASK_SAMPLE && pwdata[0]);
        tStop = taskStopIn || (wr && paddr == OFS_TASK_STOP && pwdata[0]);
        tCal = taskCalIn || (wr && paddr == OFS_TASK_CAL && pwdata[0]);
        trig = 1'b0;
        goNext = 1'b0;
        hit = 1'b1;
        c = paddr[6:4];
        nc = 4'h0;
        set = '0;
        clr = '0;
        sum = s_r.acc + {{8{shaped[15]}}, shaped};
        res = 16'($signed(sum) >>> s_r.overs);
        rd = '0;
        byteAddr = '0;
        s_nxt = s_r;
        s_nxt.evtPulse = '0;
        s_nxt.anaStart = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;

        // --------------------------------------------------------
        // APB read in setup, answer in access phase
        // --------------------------------------------------------
        unique case (paddr)
            OFS_TASK_START, OFS_TASK_SAMPLE, OFS_TASK_STOP, OFS_TASK_CAL: rd = '0;
            OFS_EVENTS: rd = {24'h0, s_r.evt};
            OFS_STATUS: rd = {27'h0, s_r.running, s_r.ph != PH_IDLE, s_r.chan};
            OFS_RESOLUTION: rd = {30'h0, s_r.resolution};
            OFS_OVERSAMPLE: rd = {28'h0, s_r.overs};
            OFS_SAMPLERATE: rd = {19'h0, s_r.samMode, 1'b0, s_r.samCc};
            OFS_RESULT_BUFFER_POINTER: rd = s_r.ptr;
            OFS_RESULT_BUFFER_MAX_COUNT: rd = {17'h0, s_r.maxCnt};
            OFS_RESULT_AMOUNT: rd = {17'h0, s_r.amount};
            default: begin
                if (paddr[11:8] == OFS_CH_REGION && paddr[7] == 1'b0) begin
                    unique case (paddr[3:2])
                        CH_POS_SEL: rd = {28'h0, s_r.posSel[c]};
                        CH_NEG_SEL: rd = {28'h0, s_r.negSel[c]};
                        CH_CONFIG: rd = cfg_word(s_r, c);
                        CH_LIMIT: rd = s_r.limit[c];
                    endcase
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = rd;
            s_nxt.pslverr = !hit;
        end

        // --------------------------------------------------------
        // APB write, taken at the access edge only
        // --------------------------------------------------------
        if (wr && hit) begin
            unique case (paddr)
                OFS_EVENTS: clr = pwdata[7:0];
                OFS_RESOLUTION: s_nxt.resolution = pwdata[1:0];
                OFS_OVERSAMPLE: s_nxt.overs = (pwdata[3:0] > 4'h8) ? 4'h8 : pwdata[3:0];
                OFS_SAMPLERATE: begin
                    s_nxt.samCc = pwdata[10:0];
                    s_nxt.samMode = pwdata[SR_MODE_BIT];
                end
                OFS_RESULT_BUFFER_POINTER: s_nxt.ptr = pwdata;
                OFS_RESULT_BUFFER_MAX_COUNT: s_nxt.maxCnt = pwdata[14:0];
                default: begin
                    if (paddr[11:8] == OFS_CH_REGION) begin
                        unique case (paddr[3:2])
                            CH_POS_SEL: s_nxt.posSel[c] = pwdata[3:0];
                            CH_NEG_SEL: s_nxt.negSel[c] = pwdata[3:0];
                            CH_CONFIG: begin
                                s_nxt.gain[c] = pwdata[CFG_GAIN_LSB +: 3];
                                s_nxt.reference_select[c] = pwdata[CFG_REFERENCE_SELECT_BIT];
                                s_nxt.tacq[c] = pwdata[CFG_TACQ_LSB +: 3];
                                s_nxt.diffMode[c] = pwdata[CFG_MODE_BIT];
                                s_nxt.burst[c] = pwdata[CFG_BURST_BIT];
                            end
                            CH_LIMIT: s_nxt.limit[c] = pwdata;
                        endcase
                    end
                end
            endcase
        end

        // --------------------------------------------------------
        // Tasks
        // --------------------------------------------------------
        if (tStart) begin
            s_nxt.ptrL = s_r.ptr;
            s_nxt.maxL = s_r.maxCnt;
            s_nxt.amount = '0;
            s_nxt.running = 1'b1;
            set[EV_STARTED] = 1'b1;
        end
        if (tStop && s_r.running) begin
            s_nxt.stopPend = 1'b1;
        end
        if (tCal) begin
            s_nxt.calPend = 1'b1;
        end
        if (tSample && s_r.running && s_r.samMode) begin
            s_nxt.armed = 1'b1;
        end
        trig = s_r.running && !s_r.stopPend && (tSample || (s_r.armed && tick));

        // --------------------------------------------------------
        // Conversion sequencer
        // --------------------------------------------------------
        unique case (s_r.ph)
            PH_IDLE: begin
                nc = sac_next_chan(chEn, 4'h0);
                if (s_r.calPend) begin
                    s_nxt.calPend = 1'b0;
                    s_nxt.anaCalibrate = 1'b1;
                    s_nxt.ph = PH_CAL;
                end else if (trig && !nc[3]) begin
                    s_nxt = enter_acq(s_nxt, nc[2:0]);
                end
            end
            PH_ACQ: begin
                if (s_r.tmr <= 16'h1) begin
                    s_nxt.anaStart = 1'b1;
                    s_nxt.ph = PH_CONV;
                end else begin
                    s_nxt.tmr = s_r.tmr - 16'h1;
                end
            end
            PH_CONV: begin
                if (anaDone) begin
                    set[EV_DONE] = 1'b1;
                    if (ovsOn && s_r.ovCnt != 9'((1 << s_r.overs) - 1)) begin
                        s_nxt.acc = sum;
                        s_nxt.ovCnt = s_r.ovCnt + 9'h1;
                        s_nxt.ph = PH_IDLE;
                        if (s_r.burst[s_r.chan]) begin
                            s_nxt = enter_acq(s_nxt, s_r.chan);
                        end
                    end else begin
                        s_nxt.acc = '0;
                        s_nxt.ovCnt = '0;
                        set[EV_RESULTDONE] = 1'b1;
                        set[EV_LIMIT_HIGH] = $signed(res) >
                            $signed(s_r.limit[s_r.chan][LIM_HIGH_LSB +: 16]);
                        set[EV_LIMIT_LOW] = $signed(res) <
                            $signed(s_r.limit[s_r.chan][15:0]);
                        if (s_r.amount < s_r.maxL) begin
                            byteAddr = s_r.ptrL + {16'h0, s_r.amount, 1'b0};
                            s_nxt.dmaReq = 1'b1;
                            s_nxt.dmaAddr = {byteAddr[31:2], 2'b00};
                            s_nxt.dmaData = {res, res};
                            s_nxt.dmaStrb = byteAddr[1] ? 4'hc : 4'h3;
                            s_nxt.ph = PH_DMA;
                        end else begin
                            goNext = 1'b1;
                        end
                    end
                end
            end
            PH_DMA: begin
                if (dmaAck) begin
                    s_nxt.dmaReq = 1'b0;
                    s_nxt.amount = s_r.amount + 15'h1;
                    set[EV_END] = (s_r.amount + 15'h1) == s_r.maxL;
                    goNext = 1'b1;
                end
            end
            PH_CAL: begin
                if (anaCalDone) begin
                    s_nxt.anaCalibrate = 1'b0;
                    set[EV_CALDONE] = 1'b1;
                    s_nxt.ph = PH_IDLE;
                end
            end
        endcase

        // Next enabled channel follows straight on, no extra gap
        if (goNext) begin
            nc = sac_next_chan(chEn, {1'b0, s_r.chan} + 4'h1);
            s_nxt.ph = PH_IDLE;
            if (scanMode && !nc[3]) begin
                s_nxt = enter_acq(s_nxt, nc[2:0]);
            end
        end

        // Stop waits for a running conversion or DMA write to end
        if (s_nxt.stopPend && (s_nxt.ph == PH_IDLE || s_nxt.ph == PH_ACQ)) begin
            s_nxt.ph = PH_IDLE;
            s_nxt.stopPend = 1'b0;
            s_nxt.running = 1'b0;
            s_nxt.armed = 1'b0;
            s_nxt.acc = '0;
            s_nxt.ovCnt = '0;
            set[EV_STOPPED] = 1'b1;
        end

        // Set wins over a clear in the same cycle
        s_nxt.evt = (s_r.evt & ~clr) | set;
        s_nxt.evtPulse = set;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.ph <= PH_IDLE;
            s_r.resolution <= RESOLUTION_RST;
            s_r.samCc <= SAMCC_RST;
            s_r.limit <= {8{LIMIT_RST}};
            s_r.anaNegGround <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign evtPulse = s_r.evtPulse;
    assign anaPosSel = s_r.anaPosSel;
    assign anaNegSel = s_r.anaNegSel;
    assign anaNegGround = s_r.anaNegGround;
    assign anaGain = s_r.anaGain;
    assign anaRefSel = s_r.anaRefSel;
    assign anaStart = s_r.anaStart;
    assign anaCalibrate = s_r.anaCalibrate;
    assign dmaReq = s_r.dmaReq;
    assign dmaAddr = s_r.dmaAddr;
    assign dmaData = s_r.dmaData;
    assign dmaStrb = s_r.dmaStrb;

endmodule : sac_sar_converter

/* File: sac_sar_converter_asserts.sv */
`timescale 1ns/1ps
module sac_sar_converter_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched ports
    input wire logic taskStartIn,
    input wire logic [7:0] evtPulse,
    input wire logic anaStart,
    input wire logic anaCalibrate,
    input wire logic anaDone,
    input wire logic anaCalDone,
    input wire logic dmaReq,
    input wire logic [31:0] dmaAddr,
    input wire logic [31:0] dmaData,
    input wire logic [3:0] dmaStrb,
    input wire logic dmaAck
);
    import sac_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_STARTED: assert property (taskStartIn |=> evtPulse[EV_STARTED])
        else $error("no started event");
    AST_DONE: assert property (anaDone |=> evtPulse[EV_DONE])
        else $error("no done event");
    AST_RES_DMA: assert property ($rose(dmaReq) |-> evtPulse[EV_RESULTDONE])
        else $error("write without result");
    AST_DMA_HOLD: assert property (dmaReq && !dmaAck |=> dmaReq && $stable(dmaAddr))
        else $error("write request dropped");
    AST_HALF: assert property (dmaReq |-> dmaData[31:16] == dmaData[15:0]
        && (dmaStrb == 4'h3 || dmaStrb == 4'hc))
        else $error("bad result lane");
    AST_CAL_HOLD: assert property (anaCalibrate && !anaCalDone |=> anaCalibrate)
        else $error("calibrate dropped");
    AST_CAL_EVT: assert property (anaCalibrate && anaCalDone |=> evtPulse[EV_CALDONE])
        else $error("no calibration event");
    AST_ONE_CONV: assert property (anaStart |=> !anaStart [*8])
        else $error("conversions overlap");
    cover property (anaDone);
    cover property (dmaAck);
    cover property (anaCalDone);
endmodule : sac_sar_converter_asserts

/* File: sac_sar_converter_tb.sv */
`timescale 1ns/1ps
module sac_sar_converter_tb;
    import sac_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic taskStartIn = 0, taskSampleIn = 0, taskStopIn = 0, taskCalIn = 0;
    logic anaNegGround, anaRefSel, anaStart, anaCalibrate, anaDone, anaCalDone, dmaReq, dmaAck;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, dmaAddr, dmaData;
    logic [7:0] evtPulse;
    logic [3:0] anaPosSel, anaNegSel, dmaStrb, dly = 0;
    logic [2:0] anaGain;
    logic [15:0] anaData, raw = 0;
    int mismatches = 0, comparisons = 0, cyc = 0;
    always #5 mclk = ~mclk;
    sac_sar_converter sac_sar_converter_inst (.mclk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .taskStartIn, .taskSampleIn,
        .taskStopIn, .taskCalIn, .evtPulse, .anaPosSel, .anaNegSel, .anaNegGround, .anaGain,
        .anaRefSel, .anaStart, .anaCalibrate, .anaDone, .anaData, .anaCalDone, .dmaReq,
        .dmaAddr, .dmaData, .dmaStrb, .dmaAck);
    sac_core_model sac_core_model_inst (.mclk, .rst_n, .anaStart, .anaCalibrate, .dmaReq,
        .rawIn(raw), .dly, .anaDone, .anaData, .anaCalDone, .dmaAck);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic pin(input int k);
        @(posedge mclk);
        {taskStartIn, taskSampleIn, taskStopIn, taskCalIn} <= 4'h8 >> k;
        @(posedge mclk);
        {taskStartIn, taskSampleIn, taskStopIn, taskCalIn} <= 4'h0;
    endtask : pin
    // Mux seen at conversion start, then the write it leads to
    task automatic conv(input logic [12:0] m, input logic [31:0] d, input logic [3:0] s);
        while (anaStart !== 1'b1) @(negedge mclk);
        chk("mux", m, {anaPosSel, anaNegGround, anaNegSel, anaGain, anaRefSel});
        while (dmaReq !== 1'b1) @(negedge mclk);
        chk("addr", 32'h1000, dmaAddr);
        chk("data", d, dmaData);
        chk("strb", s, dmaStrb);
        while (dmaReq === 1'b1) @(negedge mclk);
    endtask : conv
    task automatic ev(input int b);
        apb(0, OFS_EVENTS, 0);
        chk("event", 1, rd[b]);
    endtask : ev
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test;
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        apb(0, OFS_RESOLUTION, 0);
        chk("res", 1, rd);
        apb(0, 12'h30c, 0);
        chk("limit", LIMIT_RST, rd);
        apb(0, 12'hff0, 0);
        chk("unmapped", 1, rerr);
        $display("reset test done");
        apb(1, OFS_RESULT_BUFFER_POINTER, 32'h1000);
        apb(1, OFS_RESULT_BUFFER_MAX_COUNT, 2);
        pin(0);
        apb(1, 12'h300, 1);
        raw <= 16'h1000;
        pin(1);
        conv(13'h300, 32'h01000100, 4'h3);
        $display("one-shot test done");
        apb(1, 12'h304, 2);
        apb(1, 12'h308, 32'h00101300);
        apb(1, OFS_RESOLUTION, 2);
        raw <= 16'hf000;
        apb(1, OFS_TASK_SAMPLE, 1);
        conv(13'h227, 32'hfe00fe00, 4'hc);
        ev(EV_END);
        pin(2);
        ev(EV_STOPPED);
        $display("differential test done");
        apb(1, OFS_EVENTS, 32'hff);
        apb(1, 12'h30c, 32'h7fff0000);
        apb(1, 12'h310, 2);
        apb(1, OFS_RESULT_BUFFER_MAX_COUNT, 4);
        dly <= 4'h5;
        pin(0);
        apb(1, OFS_TASK_SAMPLE, 1);
        conv(13'h227, 32'hfe00fe00, 4'h3);
        conv(13'h500, 32'hfc00fc00, 4'hc);
        ev(EV_LIMIT_LOW);
        apb(0, OFS_RESULT_AMOUNT, 0);
        chk("amount", 2, rd);
        $display("scan test done");
        pin(3);
        repeat (30) @(posedge mclk);
        ev(EV_CALDONE);
        $display("calibration test done");
        stop_test;
    end
endmodule : sac_sar_converter_tb
bind sac_sar_converter sac_sar_converter_asserts sac_sar_converter_asserts_inst (.mclk,
    .rst_n, .taskStartIn, .evtPulse, .anaStart, .anaCalibrate, .anaDone, .anaCalDone,
    .dmaReq, .dmaAddr, .dmaData, .dmaStrb, .dmaAck);
